// file: shared/atr_pkg.sv
// Purpose: constants for the tap parameter and result register block
// Assumes: 8-bit register space reached over the two-wire serial port
// Notes: status tap bits follow the tap control enable layout
package atr_pkg;
	// register addresses
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_TAP_FEAT = 8'h08;
	localparam logic [7:0] ADDR_TAP_CTRL = 8'h09;
	localparam logic [7:0] ADDR_TAP_X = 8'h0a;
	localparam logic [7:0] ADDR_TAP_Y = 8'h0b;
	localparam logic [7:0] ADDR_TAP_Z = 8'h0c;
	localparam logic [7:0] ADDR_X_LOW = 8'h0d;
	localparam logic [7:0] ADDR_X_HIGH = 8'h0e;
	localparam logic [7:0] ADDR_Y_LOW = 8'h0f;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h10;
	localparam logic [7:0] ADDR_Z_LOW = 8'h11;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h12;
	localparam logic [7:0] ADDR_FMT = 8'h20;
	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] RST_RESULT = 16'h0000;
	// tap control fields
	localparam int TAPC_GLOBAL_EN = 7;
	localparam int TAPC_BANK = 6;
	// tap feature fields
	localparam int FEAT_LATCH = 7;
	localparam int FEAT_SWAP_Z = 6;
	localparam int FEAT_SWAP_Y = 5;
	localparam int FEAT_SWAP_X = 4;
	localparam int FEAT_RATE_LSB = 0;
	// per-axis timing fields
	localparam int TIM_QUIET_LSB = 4;
	localparam int TIM_LEN_LSB = 0;
	// format register fields
	localparam int FMT_RANGE_LSB = 4;
	localparam int FMT_RES_LSB = 0;
	localparam logic [7:0] FMT_WR_MASK = 8'h77;
	// raw sample width at full resolution
	localparam int RAW_W = 14;
	localparam logic [3:0] FULL_BITS = 4'he;

	typedef enum logic [2:0] {
		ATR_RES_6, ATR_RES_7, ATR_RES_8, ATR_RES_10, ATR_RES_12, ATR_RES_14,
		ATR_RES_RSV6, ATR_RES_RSV7
	} atr_res_t;

	typedef enum logic [2:0] {
		ATR_RANGE_2G, ATR_RANGE_4G, ATR_RANGE_8G, ATR_RANGE_16G, ATR_RANGE_12G,
		ATR_RANGE_RSV5, ATR_RANGE_RSV6, ATR_RANGE_RSV7
	} atr_range_t;

	// result width in bits for a resolution code; reserved codes give full width
	function automatic logic [3:0] res_bits(input logic [2:0] code);
		case (atr_res_t'(code))
			ATR_RES_6: res_bits = 4'h6;
			ATR_RES_7: res_bits = 4'h7;
			ATR_RES_8: res_bits = 4'h8;
			ATR_RES_10: res_bits = 4'ha;
			ATR_RES_12: res_bits = 4'hc;
			default: res_bits = FULL_BITS;
		endcase
	endfunction : res_bits
endpackage : atr_pkg

// file: rtl/atr_tap_axis.sv
// Purpose: tap qualification for one axis
// Assumes: i_update pulses once per applied sample
// Notes: direction is the sign of the first above-threshold sample, inverted when i_swap is high
`timescale 1ns/1ps
module atr_tap_axis (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_update,
	input wire logic signed [15:0] i_accel,
	input wire logic [7:0] i_thresh,
	input wire logic [3:0] i_max_len,
	input wire logic [3:0] i_quiet,
	input wire logic i_global_en,
	input wire logic i_pos_en,
	input wire logic i_neg_en,
	input wire logic i_swap,
	output logic o_tap_pos,
	output logic o_tap_neg
);
	import atr_pkg::*;

	logic [16:0] mag;
	logic above;
	logic [4:0] run_len;
	logic first_neg;
	logic [3:0] quiet_left;
	logic rep_neg;
	logic rep_en;

	assign mag = i_accel[15] ? 17'(-$signed({i_accel[15], i_accel})) : {1'b0, i_accel};
	assign above = mag >= {9'h000, i_thresh};
	assign rep_neg = first_neg ^ i_swap;
	assign rep_en = i_global_en && (rep_neg ? i_neg_en : i_pos_en);

	always_ff @(posedge i_ref_clk) begin
		o_tap_pos <= 1'b0;
		o_tap_neg <= 1'b0;
		if (i_rst) begin
			run_len <= 5'h00;
			first_neg <= 1'b0;
			quiet_left <= 4'h0;
		end else if (!i_global_en) begin
			run_len <= 5'h00;
			quiet_left <= 4'h0;
		end else if (i_update) begin
			if (quiet_left != 4'h0) begin
				quiet_left <= quiet_left - 4'h1;
				run_len <= 5'h00;
			end else if (above) begin
				if (run_len == 5'h00) begin
					first_neg <= i_accel[15];
				end
				if (run_len != 5'h1f) begin
					run_len <= run_len + 5'h01;
				end
			end else begin
				// too long a snap is dropped silently
				if (run_len != 5'h00 && run_len <= {1'b0, i_max_len} && rep_en) begin
					o_tap_pos <= !rep_neg;
					o_tap_neg <= rep_neg;
					quiet_left <= i_quiet;
				end
				run_len <= 5'h00;
			end
		end
	end
endmodule : atr_tap_axis

// file: rtl/atr_top.sv
// Purpose: tap parameter, result and format registers behind a two-wire slave
// Assumes: scl and sda are synchronous to i_ref_clk and slow against it
// Notes: sda is open drain; the slave never stretches scl
`timescale 1ns/1ps
module atr_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_sample_valid,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_x_raw,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_y_raw,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_z_raw,
	output logic [2:0] o_range_sel,
	output logic [3:0] o_rate_sel
);
	import atr_pkg::*;

	typedef enum {
		S_IDLE, S_ADDR, S_ACK_A, S_REG, S_ACK_R, S_WR, S_ACK_W, S_RD, S_ACK_RD
	} atr_state_t;

	atr_state_t state;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [2:0] bit_cnt;
	logic byte_done;
	logic [7:0] shreg;
	logic [7:0] rd_sh;
	logic [7:0] rd_byte;
	logic [7:0] ptr;
	logic rw;
	logic m_ack;
	logic busy;
	logic sr_read;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	logic [7:0] tap_ctrl;
	logic [7:0] tap_feat;
	logic [7:0] tap_tim [3];
	logic [7:0] tap_thr [3];
	logic [7:0] fmt;
	logic [15:0] res_x;
	logic [15:0] res_y;
	logic [15:0] res_z;
	logic [5:0] status;
	logic [5:0] tap_pend;
	logic [5:0] det;

	logic pend_valid;
	logic [RAW_W-1:0] pend_x;
	logic [RAW_W-1:0] pend_y;
	logic [RAW_W-1:0] pend_z;
	logic apply;
	logic upd_q;

	// pointer advance with wrap from last result byte to status
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		next_ptr = (p == ADDR_Z_HIGH) ? ADDR_STATUS : p + 8'h01;
	endfunction : next_ptr

	// scale a full-width sample to the selected resolution
	function automatic logic [15:0] fmt_axis(input logic [RAW_W-1:0] raw,
		input logic [2:0] code);
		logic signed [15:0] wide;
		logic [3:0] sh;
		wide = 16'($signed(raw));
		sh = FULL_BITS - res_bits(code);
		fmt_axis = 16'(wide >>> sh);
	endfunction : fmt_axis

	function automatic logic [7:0] rd_data(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == ADDR_STATUS) begin
			d = {2'b00, status};
		end else if (a == ADDR_TAP_FEAT) begin
			d = tap_feat;
		end else if (a == ADDR_TAP_CTRL) begin
			d = tap_ctrl;
		end else if (a >= ADDR_TAP_X && a <= ADDR_TAP_Z) begin
			d = tap_ctrl[TAPC_BANK] ? tap_thr[2'(a - ADDR_TAP_X)]
				: tap_tim[2'(a - ADDR_TAP_X)];
		end else if (a == ADDR_X_LOW) begin
			d = res_x[7:0];
		end else if (a == ADDR_X_HIGH) begin
			d = res_x[15:8];
		end else if (a == ADDR_Y_LOW) begin
			d = res_y[7:0];
		end else if (a == ADDR_Y_HIGH) begin
			d = res_y[15:8];
		end else if (a == ADDR_Z_LOW) begin
			d = res_z[7:0];
		end else if (a == ADDR_Z_HIGH) begin
			d = res_z[15:8];
		end else if (a == ADDR_FMT) begin
			d = fmt;
		end
		rd_data = d;
	endfunction : rd_data

	assign scl_rise = i_scl && !scl_q;
	assign scl_fall = !i_scl && scl_q;
	assign start_cond = scl_q && i_scl && sda_q && !i_sda;
	assign stop_cond = scl_q && i_scl && !sda_q && i_sda;
	assign apply = pend_valid && !busy;
	assign o_range_sel = fmt[FMT_RANGE_LSB +: 3];
	assign o_rate_sel = tap_feat[FEAT_RATE_LSB +: 4];

	// byte at the pointer, ready to be shifted out
	always_comb begin
		rd_byte = rd_data(ptr);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	// serial slave
	always_ff @(posedge i_ref_clk) begin
		wr_en <= 1'b0;
		if (i_rst) begin
			state <= S_IDLE;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			shreg <= RST_REG;
			rd_sh <= RST_REG;
			ptr <= RST_REG;
			rw <= 1'b0;
			m_ack <= 1'b0;
			o_sda <= 1'b0;
			o_sda_oe_n <= 1'b1;
			wr_addr <= RST_REG;
			wr_data <= RST_REG;
		end else if (start_cond) begin
			state <= S_ADDR;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (stop_cond) begin
			state <= S_IDLE;
			o_sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			if (state == S_ACK_RD) begin
				m_ack <= !i_sda;
			end else if (state != S_IDLE && state != S_ACK_A && state != S_ACK_R
				&& state != S_ACK_W) begin
				shreg <= {shreg[6:0], i_sda};
				bit_cnt <= bit_cnt + 3'h1;
				byte_done <= (bit_cnt == 3'h7);
			end
		end else if (scl_fall) begin
			case (state)
				S_ADDR: begin
					if (byte_done) begin
						byte_done <= 1'b0;
						if (shreg[7:1] == DEV_ADDR) begin
							rw <= shreg[0];
							o_sda_oe_n <= 1'b0;
							state <= S_ACK_A;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_ACK_A: begin
					if (rw) begin
						rd_sh <= {rd_byte[6:0], 1'b0};
						o_sda_oe_n <= rd_byte[7];
						ptr <= next_ptr(ptr);
						state <= S_RD;
					end else begin
						o_sda_oe_n <= 1'b1;
						state <= S_REG;
					end
				end
				S_REG: begin
					if (byte_done) begin
						byte_done <= 1'b0;
						ptr <= shreg;
						o_sda_oe_n <= 1'b0;
						state <= S_ACK_R;
					end
				end
				S_ACK_R, S_ACK_W: begin
					o_sda_oe_n <= 1'b1;
					state <= S_WR;
				end
				S_WR: begin
					if (byte_done) begin
						byte_done <= 1'b0;
						wr_en <= 1'b1;
						wr_addr <= ptr;
						wr_data <= shreg;
						ptr <= next_ptr(ptr);
						o_sda_oe_n <= 1'b0;
						state <= S_ACK_W;
					end
				end
				S_RD: begin
					if (byte_done) begin
						byte_done <= 1'b0;
						o_sda_oe_n <= 1'b1;
						state <= S_ACK_RD;
					end else begin
						o_sda_oe_n <= rd_sh[7];
						rd_sh <= {rd_sh[6:0], 1'b0};
					end
				end
				S_ACK_RD: begin
					if (m_ack) begin
						rd_sh <= {rd_byte[6:0], 1'b0};
						o_sda_oe_n <= rd_byte[7];
						ptr <= next_ptr(ptr);
						state <= S_RD;
					end else begin
						o_sda_oe_n <= 1'b1;
						state <= S_IDLE;
					end
				end
				default: begin
					o_sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// transaction window and status-read tracking
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			busy <= 1'b0;
			sr_read <= 1'b0;
		end else begin
			if (start_cond) begin
				busy <= 1'b1;
			end else if (stop_cond) begin
				busy <= 1'b0;
			end
			if (scl_fall && (state == S_ACK_A && rw || state == S_ACK_RD && m_ack)
				&& ptr == ADDR_STATUS) begin
				sr_read <= 1'b1;
			end else if (!busy) begin
				sr_read <= 1'b0;
			end
		end
	end

	// configuration writes
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tap_ctrl <= RST_REG;
			tap_feat <= RST_REG;
			fmt <= RST_REG;
			for (int i = 0; i < 3; i++) begin
				tap_tim[i] <= RST_REG;
				tap_thr[i] <= RST_REG;
			end
		end else if (wr_en) begin
			if (wr_addr == ADDR_TAP_FEAT) begin
				tap_feat <= wr_data;
			end else if (wr_addr == ADDR_TAP_CTRL) begin
				tap_ctrl <= wr_data;
			end else if (wr_addr >= ADDR_TAP_X && wr_addr <= ADDR_TAP_Z) begin
				if (tap_ctrl[TAPC_BANK]) begin
					tap_thr[2'(wr_addr - ADDR_TAP_X)] <= wr_data;
				end else begin
					tap_tim[2'(wr_addr - ADDR_TAP_X)] <= wr_data;
				end
			end else if (wr_addr == ADDR_FMT) begin
				// bit 7 and reserved bit 3 read back as zero
				fmt <= wr_data & FMT_WR_MASK;
			end
		end
	end

	// sample capture, held back during a transfer
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pend_valid <= 1'b0;
			pend_x <= '0;
			pend_y <= '0;
			pend_z <= '0;
		end else if (i_sample_valid) begin
			pend_valid <= 1'b1;
			pend_x <= i_x_raw;
			pend_y <= i_y_raw;
			pend_z <= i_z_raw;
		end else if (apply) begin
			pend_valid <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			res_x <= RST_RESULT;
			res_y <= RST_RESULT;
			res_z <= RST_RESULT;
			upd_q <= 1'b0;
		end else begin
			upd_q <= apply;
			if (apply) begin
				res_x <= fmt_axis(pend_x, fmt[FMT_RES_LSB +: 3]);
				res_y <= fmt_axis(pend_y, fmt[FMT_RES_LSB +: 3]);
				res_z <= fmt_axis(pend_z, fmt[FMT_RES_LSB +: 3]);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			atr_tap_axis u_tap (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_update(upd_q),
				.i_accel(g == 0 ? res_x : g == 1 ? res_y : res_z),
				.i_thresh(tap_thr[g]),
				.i_max_len(tap_tim[g][TIM_LEN_LSB +: 4]),
				.i_quiet(tap_tim[g][TIM_QUIET_LSB +: 4]),
				.i_global_en(tap_ctrl[TAPC_GLOBAL_EN]),
				.i_pos_en(tap_ctrl[2*g]),
				.i_neg_en(tap_ctrl[2*g+1]),
				.i_swap(tap_feat[FEAT_SWAP_X+g]),
				.o_tap_pos(det[2*g]),
				.o_tap_neg(det[2*g+1])
			);
		end
	endgenerate

	// status merge; new taps win over a pending clear
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			status <= 6'h00;
			tap_pend <= 6'h00;
		end else if (busy) begin
			tap_pend <= tap_pend | det;
		end else begin
			tap_pend <= det;
			if (tap_feat[FEAT_LATCH] && !sr_read && status != 6'h00) begin
				status <= status;
			end else begin
				status <= (sr_read ? 6'h00 : status) | tap_pend;
			end
		end
	end
endmodule : atr_top

// file: sim/atr_top_props.sv
// Purpose: port checker for the tap and result register block
// Assumes: host holds sda steady while scl is high
// Notes: attached to atr_top by bind
`timescale 1ns/1ps
module atr_top_props (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	input wire logic i_sample_valid,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_x_raw,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_y_raw,
	input wire logic signed [atr_pkg::RAW_W-1:0] i_z_raw,
	input wire logic [2:0] o_range_sel,
	input wire logic [3:0] o_rate_sel
);
	import atr_pkg::*;
	logic in_xfer;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// high from start until stop
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			in_xfer <= 1'b0;
		else if (i_scl && $past(i_scl) && $past(i_sda) != i_sda)
			in_xfer <= !i_sda;
	end
	sequence s_start;
		i_scl && i_sda ##1 i_scl && !i_sda;
	endsequence
	sequence s_stop;
		i_scl && !i_sda ##1 i_scl && i_sda;
	endsequence
	sequence s_scl_fell;
		$past(i_scl, 2) && !$past(i_scl);
	endsequence
	// a written byte lands one clock after the drive point
	sequence s_wr_landed;
		$past(i_scl, 3) && !$past(i_scl, 2);
	endsequence
	a_start_no_drive: assert property (s_start |=> o_sda_oe_n [*4])
		else $error("sda driven after start");
	a_stop_release: assert property (s_stop |=> o_sda_oe_n [*3])
		else $error("sda driven after stop");
	a_idle_release: assert property (!in_xfer && !$past(in_xfer) |-> o_sda_oe_n)
		else $error("sda driven while bus idle");
	a_drive_after_fall: assert property ($changed(o_sda_oe_n) |-> s_scl_fell)
		else $error("sda drive moved off the scl fall");
	a_scl_high_hold: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
		else $error("sda drive moved while scl high");
	a_reset_default: assert property ($past(i_rst) |-> o_sda_oe_n && o_range_sel == 3'h0
		&& o_rate_sel == 4'h0)
		else $error("outputs not at reset values");
	a_range_on_write: assert property ($changed(o_range_sel) |-> s_wr_landed)
		else $error("range moved off a written byte");
	a_range_idle_hold: assert property (!in_xfer |-> $stable(o_range_sel))
		else $error("range moved while bus idle");
endmodule : atr_top_props
bind atr_top atr_top_props i_atr_top_props (.i_ref_clk, .i_rst, .i_scl, .i_sda, .o_sda,
	.o_sda_oe_n, .i_sample_valid, .i_x_raw, .i_y_raw, .i_z_raw, .o_range_sel, .o_rate_sel);

// file: sim/atr_host_model.sv
// Purpose: two-wire bus master standing in for the host controller
// Assumes: scl high for five reference clocks and low for six
// Notes: o_sda_drv high means released; the line is pulled up
`timescale 1ns/1ps
module atr_host_model (
	input wire logic i_ref_clk,
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda_drv
);
	initial begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : hc
	task automatic put_bit(input logic b);
		o_sda_drv <= b;
		hc(5);
		o_scl <= 1'b1;
		hc(5);
		o_scl <= 1'b0;
		hc(1);
	endtask : put_bit
	task automatic get_bit(output logic b);
		o_sda_drv <= 1'b1;
		hc(5);
		o_scl <= 1'b1;
		hc(4);
		b = i_sda_line;
		hc(1);
		o_scl <= 1'b0;
		hc(1);
	endtask : get_bit
	// also serves as repeated start
	task automatic start;
		o_sda_drv <= 1'b1;
		hc(5);
		o_scl <= 1'b1;
		hc(5);
		o_sda_drv <= 1'b0;
		hc(5);
		o_scl <= 1'b0;
		hc(1);
	endtask : start
	task automatic stop;
		o_sda_drv <= 1'b0;
		hc(5);
		o_scl <= 1'b1;
		hc(5);
		o_sda_drv <= 1'b1;
		hc(5);
	endtask : stop
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic nak;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(nak);
		ack = !nak;
	endtask : put_byte
	task automatic get_byte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(last);
	endtask : get_byte
endmodule : atr_host_model

// file: sim/tb_atr_top.sv
// Purpose: self-checking bench for the tap parameter and result registers
// Assumes: the host model is the only bus master
// Notes: samples stay inside the 14-bit signed range
`timescale 1ns/1ps
module tb_atr_top;
	import atr_pkg::*;
	localparam logic [6:0] DEV = 7'h2a;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_scl, i_sda, o_sda, o_sda_oe_n, host_sda;
	logic i_sample_valid = 1'b0;
	logic signed [RAW_W-1:0] i_x_raw = '0, i_y_raw = '0, i_z_raw = '0;
	logic [2:0] o_range_sel;
	logic [3:0] o_rate_sel;
	logic [7:0] rb [8];
	int fails = 0, check_count = 0, cyc = 0;
	always #20 i_ref_clk = ~i_ref_clk;
	assign i_sda = host_sda & (o_sda_oe_n | o_sda);
	atr_top #(.DEV_ADDR(DEV)) i_atr_top (.i_ref_clk, .i_rst, .i_scl, .i_sda, .o_sda,
		.o_sda_oe_n, .i_sample_valid, .i_x_raw, .i_y_raw, .i_z_raw, .o_range_sel, .o_rate_sel);
	atr_host_model i_atr_host_model (.i_ref_clk, .i_sda_line(i_sda), .o_scl(i_scl),
		.o_sda_drv(host_sda));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			test_done();
		end
	end
	task automatic pulse;
		i_sample_valid <= 1'b1;
		@(posedge i_ref_clk);
		i_sample_valid <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask : pulse
	task automatic samp(input int x, input int y, input int z);
		i_x_raw <= RAW_W'(x);
		i_y_raw <= RAW_W'(y);
		i_z_raw <= RAW_W'(z);
		pulse();
	endtask : samp
	task automatic snap(input int v, input int n);
		for (int i = 0; i < n; i++)
			samp(v, 0, 0);
		samp(0, 0, 0);
	endtask : snap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic k;
		i_atr_host_model.start();
		i_atr_host_model.put_byte({DEV, 1'b0}, k);
		i_atr_host_model.put_byte(a, k);
		i_atr_host_model.put_byte(d, k);
		i_atr_host_model.stop();
	endtask : wr
	// whole burst in one transfer; mid pulses a sample inside it
	task automatic rd(input logic [7:0] a, input int n, input logic mid);
		logic k;
		i_atr_host_model.start();
		i_atr_host_model.put_byte({DEV, 1'b0}, k);
		i_atr_host_model.put_byte(a, k);
		if (mid)
			pulse();
		i_atr_host_model.start();
		i_atr_host_model.put_byte({DEV, 1'b1}, k);
		for (int i = 0; i < n; i++)
			i_atr_host_model.get_byte(rb[i], i == n - 1);
		i_atr_host_model.stop();
	endtask : rd
	task automatic status_is(input logic [7:0] e);
		rd(ADDR_STATUS, 1, 1'b0);
		check("status", 16'(rb[0]), 16'(e));
	endtask : status_is
	task automatic t_reset;
		rd(ADDR_FMT, 1, 1'b0);
		check("fmt", 16'(rb[0]), 16'h0000);
		check("range", 16'(o_range_sel), 16'h0000);
		rd(ADDR_X_LOW, 7, 1'b0);
		for (int i = 0; i < 7; i++)
			check("result", 16'(rb[i]), 16'h0000);
		rd(8'h13, 1, 1'b0);
		check("unmapped", 16'(rb[0]), 16'h0000);
	endtask : t_reset
	task automatic t_format;
		int sh [6] = '{8, 7, 6, 4, 2, 0};
		for (int c = 0; c < 6; c++) begin
			wr(ADDR_FMT, {1'b0, 3'(c % 5), 1'b1, 3'(c)});
			check("range", 16'(o_range_sel), 16'(c % 5));
			samp(-8100, 8191, -3);
			rd(ADDR_X_LOW, 6, 1'b0);
			check("x", {rb[1], rb[0]}, 16'(-8100 >>> sh[c]));
			check("y", {rb[3], rb[2]}, 16'(8191 >>> sh[c]));
			check("z", {rb[5], rb[4]}, 16'(-3 >>> sh[c]));
		end
		rd(ADDR_FMT, 1, 1'b0);
		check("fmt", 16'(rb[0]), 16'h0005);
	endtask : t_format
	task automatic t_coherent;
		i_x_raw <= 14'sd1000;
		rd(ADDR_X_LOW, 2, 1'b1);
		check("held", {rb[1], rb[0]}, 16'he05c);
		rd(ADDR_X_LOW, 2, 1'b0);
		check("new", {rb[1], rb[0]}, 16'h03e8);
	endtask : t_coherent
	task automatic t_bank;
		wr(ADDR_TAP_X, 8'h35);
		wr(ADDR_TAP_CTRL, 8'h40);
		wr(ADDR_TAP_X, 8'h20);
		rd(ADDR_TAP_X, 1, 1'b0);
		check("thresh", 16'(rb[0]), 16'h0020);
		wr(ADDR_TAP_CTRL, 8'h00);
		rd(ADDR_TAP_X, 1, 1'b0);
		check("timing", 16'(rb[0]), 16'h0035);
	endtask : t_bank
	task automatic t_tap;
		samp(0, 0, 0);
		wr(ADDR_TAP_X, 8'h22);
		wr(ADDR_TAP_CTRL, 8'h81);
		snap(100, 2);
		rd(ADDR_Z_HIGH, 2, 1'b0);
		check("wrap", 16'(rb[1]), 16'h0001);
		snap(100, 1);
		status_is(8'h00);
		snap(100, 1);
		status_is(8'h01);
		snap(0, 2);
		snap(100, 3);
		status_is(8'h00);
		snap(20, 1);
		status_is(8'h00);
		snap(-100, 1);
		status_is(8'h00);
		wr(ADDR_TAP_FEAT, 8'h10);
		snap(-100, 1);
		status_is(8'h01);
		snap(0, 2);
		wr(ADDR_TAP_FEAT, 8'h80);
		wr(ADDR_TAP_CTRL, 8'h83);
		snap(100, 1);
		snap(0, 2);
		snap(-100, 1);
		status_is(8'h01);
		wr(ADDR_TAP_CTRL, 8'h01);
		snap(100, 1);
		status_is(8'h00);
	endtask : t_tap
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		t_reset();
		t_format();
		t_coherent();
		t_bank();
		t_tap();
		test_done();
	end
endmodule : tb_atr_top
